// >>> hdl/bcm_top.v
// Ballast chopper controller and thermal monitor with AXI4-Lite registers.
// Assumes the DC-link voltage word arrives in millivolts, synchronous to
// the system clock, and that the bus master follows AXI4-Lite handshakes.
//
// Summary of operation
// - Output stays off unless enable bit set.
// - Pin active high; invert bit makes active low.
// - Threshold and hysteresis come from consecutive entries.
// - Overvoltage despite ballast: error, output stage off.
// - Accumulate switched-on energy minus convective cooling.
// - Energy over limit blocks switching, logs overload warning.
// - Block clears itself once resistor has cooled.
// - Nominal milliohm resistance gives converted power.
// - Cooling milliwatts drain the accumulator continuously.
// - Short surge energy checked against short limit.
// - Energy within reference time checked against long limit.
// - Invalid resistor parameters raise parameter fault.
// - Pin drives external driver, switch and resistor.
//
// Register access over AXI4-Lite was decided locally.
`include "bcm_map.vh"

module bcm_top #(
   parameter TICK_CYCLES = `BCM_TICK_CYC,
   parameter SHORT_WIN_MS = `BCM_SHORT_WIN_MS
) (
   input wire CLK_SYS_I,
   input wire RSTN_I,
   input wire [31:0] VDC_MV_I,
   output wire BALLAST_O,
   output wire STAGE_OFF_O,
   output wire IRQ_O,
   input wire [7:0] S_AXI_AWADDR_I,
   input wire S_AXI_AWVALID_I,
   output wire S_AXI_AWREADY_O,
   input wire [31:0] S_AXI_WDATA_I,
   input wire [3:0] S_AXI_WSTRB_I,
   input wire S_AXI_WVALID_I,
   output wire S_AXI_WREADY_O,
   output wire [1:0] S_AXI_BRESP_O,
   output wire S_AXI_BVALID_O,
   input wire S_AXI_BREADY_I,
   input wire [7:0] S_AXI_ARADDR_I,
   input wire S_AXI_ARVALID_I,
   output wire S_AXI_ARREADY_O,
   output wire [31:0] S_AXI_RDATA_O,
   output wire [1:0] S_AXI_RRESP_O,
   output wire S_AXI_RVALID_O,
   input wire S_AXI_RREADY_I
);

   localparam ST_OFF = 3'b001;
   localparam ST_ON = 3'b010;
   localparam ST_BLOCK = 3'b100;

   reg [31:0] cfg_reg, thr_reg, hyst_reg, res_reg;
   reg [31:0] llim_reg, lref_reg, slim_reg, cool_reg, ovlim_reg;
   reg [`BCM_STW-1:0] status_reg, mask_reg;
   reg [15:0] code_reg;
   reg [2:0] state_reg;
   reg pin_reg, stage_off_reg;
   reg [47:0] acc_reg, short_reg, long_reg;
   reg [31:0] short_cnt_reg, long_cnt_reg, tick_cnt_reg;
   reg [63:0] dvd_reg, quo_reg;
   reg [32:0] rem_reg;
   reg [6:0] div_cnt_reg;
   reg [31:0] pwr_reg;
   wire param_bad;

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   reg aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
   reg [5:0] aw_idx_reg;
   reg [31:0] wdata_reg, rdata_reg;
   reg [3:0] wstrb_reg;
   reg [1:0] bresp_reg, rresp_reg;
   wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
   wire do_read = S_AXI_ARVALID_I && !rvalid_reg;
   wire [5:0] ar_idx = S_AXI_ARADDR_I[7:2];
   reg [31:0] rd_val;
   reg rd_hit;
   wire wr_hit = (aw_idx_reg >= `BCM_IDX_CFG && aw_idx_reg <= `BCM_IDX_COOL)
      || aw_idx_reg == `BCM_IDX_STATUS || aw_idx_reg == `BCM_IDX_MASK
      || aw_idx_reg == `BCM_IDX_OVLIM;

   assign S_AXI_AWREADY_O = !aw_full_reg;
   assign S_AXI_WREADY_O = !w_full_reg;
   assign S_AXI_BVALID_O = bvalid_reg;
   assign S_AXI_BRESP_O = bresp_reg;
   assign S_AXI_ARREADY_O = !rvalid_reg;
   assign S_AXI_RVALID_O = rvalid_reg;
   assign S_AXI_RDATA_O = rdata_reg;
   assign S_AXI_RRESP_O = rresp_reg;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               merge[k*8 +: 8] = data[k*8 +: 8];
            end
         end
      end
   endfunction

   always @* begin
      rd_hit = 1'b1;
      case (ar_idx)
         `BCM_IDX_CFG: rd_val = cfg_reg;
         `BCM_IDX_THR: rd_val = thr_reg;
         `BCM_IDX_HYST: rd_val = hyst_reg;
         `BCM_IDX_RES: rd_val = res_reg;
         `BCM_IDX_LLIM: rd_val = llim_reg;
         `BCM_IDX_LREF: rd_val = lref_reg;
         `BCM_IDX_SLIM: rd_val = slim_reg;
         `BCM_IDX_COOL: rd_val = cool_reg;
         `BCM_IDX_STATUS: rd_val = {29'h0, status_reg};
         `BCM_IDX_MASK: rd_val = {29'h0, mask_reg};
         `BCM_IDX_STATE: rd_val = {27'h0, param_bad, stage_off_reg,
            state_reg == ST_BLOCK, state_reg == ST_ON, pin_reg};
         `BCM_IDX_ENERGY: rd_val = acc_reg[31:0];
         `BCM_IDX_OVLIM: rd_val = ovlim_reg;
         `BCM_IDX_CODE: rd_val = {16'h0, code_reg};
         default: begin
            rd_val = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         aw_idx_reg <= 6'h00;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         bresp_reg <= `BCM_RESP_OKAY;
         rresp_reg <= `BCM_RESP_OKAY;
         rdata_reg <= 32'h0;
      end else begin
         if (S_AXI_AWVALID_I && !aw_full_reg) begin
            aw_full_reg <= 1'b1;
            aw_idx_reg <= S_AXI_AWADDR_I[7:2];
         end
         if (S_AXI_WVALID_I && !w_full_reg) begin
            w_full_reg <= 1'b1;
            wdata_reg <= S_AXI_WDATA_I;
            wstrb_reg <= S_AXI_WSTRB_I;
         end
         if (do_write) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? `BCM_RESP_OKAY : `BCM_RESP_SLVERR;
         end else if (bvalid_reg && S_AXI_BREADY_I) begin
            bvalid_reg <= 1'b0;
         end
         if (do_read) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_val;
            rresp_reg <= rd_hit ? `BCM_RESP_OKAY : `BCM_RESP_SLVERR;
         end else if (rvalid_reg && S_AXI_RREADY_I) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   wire wr_cfg = do_write && aw_idx_reg == `BCM_IDX_CFG;
   wire wr_status = do_write && aw_idx_reg == `BCM_IDX_STATUS;
   wire rd_status = do_read && ar_idx == `BCM_IDX_STATUS;

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         cfg_reg <= `BCM_RST_WORD;
         thr_reg <= `BCM_RST_WORD;
         hyst_reg <= `BCM_RST_WORD;
         res_reg <= `BCM_RST_WORD;
         llim_reg <= `BCM_RST_WORD;
         lref_reg <= `BCM_RST_WORD;
         slim_reg <= `BCM_RST_WORD;
         cool_reg <= `BCM_RST_WORD;
         mask_reg <= 3'h0;
         ovlim_reg <= `BCM_RST_OVLIM;
      end else if (do_write) begin
         case (aw_idx_reg)
            `BCM_IDX_CFG: cfg_reg <= merge(cfg_reg, wdata_reg, wstrb_reg);
            `BCM_IDX_THR: thr_reg <= merge(thr_reg, wdata_reg, wstrb_reg);
            `BCM_IDX_HYST: hyst_reg <= merge(hyst_reg, wdata_reg, wstrb_reg);
            `BCM_IDX_RES: res_reg <= merge(res_reg, wdata_reg, wstrb_reg);
            `BCM_IDX_LLIM: llim_reg <= merge(llim_reg, wdata_reg, wstrb_reg);
            `BCM_IDX_LREF: lref_reg <= merge(lref_reg, wdata_reg, wstrb_reg);
            `BCM_IDX_SLIM: slim_reg <= merge(slim_reg, wdata_reg, wstrb_reg);
            `BCM_IDX_COOL: cool_reg <= merge(cool_reg, wdata_reg, wstrb_reg);
            `BCM_IDX_MASK: mask_reg <= wstrb_reg[0] ? wdata_reg[2:0] : mask_reg;
            `BCM_IDX_OVLIM: ovlim_reg <= merge(ovlim_reg, wdata_reg, wstrb_reg);
            default: cfg_reg <= cfg_reg;
         endcase
      end
   end

   // ****************************************************************
   // Parameter check and scaled limits
   // ****************************************************************
   wire enabled = cfg_reg[`BCM_CFG_EN];
   // A zero resistance would make the power figure meaningless.
   assign param_bad = enabled && (res_reg == 32'h0 || lref_reg == 32'h0 ||
      cool_reg == 32'h0 || slim_reg == 32'h0 || llim_reg < slim_reg ||
      hyst_reg >= thr_reg);
   wire [47:0] llim_uws = llim_reg * `BCM_MS_PER_S;
   wire [47:0] slim_uws = slim_reg * `BCM_MS_PER_S;
   wire [32:0] off_level = {1'b0, thr_reg} - {1'b0, hyst_reg};
   wire over_thr = VDC_MV_I > thr_reg;
   wire below_off = {1'b0, VDC_MV_I} < off_level;
   wire overload = acc_reg > llim_uws || short_reg > slim_uws ||
      long_reg > llim_uws;
   wire cooled = acc_reg <= {1'b0, llim_uws[47:1]} &&
      short_reg <= slim_uws && long_reg <= llim_uws;

   // ****************************************************************
   // Switching state machine
   // ****************************************************************
   reg [2:0] state_next;
   always @* begin
      case (state_reg)
         ST_OFF: begin
            if (!enabled || param_bad)
               state_next = ST_OFF;
            else if (overload)
               state_next = ST_BLOCK;
            else if (over_thr)
               state_next = ST_ON;
            else
               state_next = ST_OFF;
         end
         ST_ON: begin
            if (!enabled || param_bad)
               state_next = ST_OFF;
            else if (overload)
               state_next = ST_BLOCK;
            else if (below_off)
               state_next = ST_OFF;
            else
               state_next = ST_ON;
         end
         ST_BLOCK: begin
            if (cooled || !enabled)
               state_next = ST_OFF;
            else
               state_next = ST_BLOCK;
         end
         default: state_next = ST_OFF;
      endcase
   end

   wire tick = tick_cnt_reg >= TICK_CYCLES - 1;
   wire block_rise = state_next == ST_BLOCK && state_reg != ST_BLOCK;
   wire ov_event = enabled && VDC_MV_I > ovlim_reg;

   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state_reg <= ST_OFF;
         pin_reg <= 1'b0;
         stage_off_reg <= 1'b0;
         tick_cnt_reg <= 32'h0;
      end else begin
         state_reg <= state_next;
         // Pin follows the state through the polarity select.
         pin_reg <= (state_next == ST_ON) ^ cfg_reg[`BCM_CFG_INV];
         if (ov_event)
            stage_off_reg <= 1'b1;
         else if (wr_status && wstrb_reg[0] && wdata_reg[`BCM_ST_OVERVOLT])
            stage_off_reg <= 1'b0;
         tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
      end
   end

   // ****************************************************************
   // Power divider: millivolts squared over milliohms gives milliwatts
   // ****************************************************************
   wire [32:0] rem_sh = {rem_reg[31:0], dvd_reg[63]};
   wire rem_ge = rem_sh >= {1'b0, res_reg};
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         dvd_reg <= 64'h0;
         quo_reg <= 64'h0;
         rem_reg <= 33'h0;
         div_cnt_reg <= 7'h00;
         pwr_reg <= 32'h0;
      end else if (tick) begin
         dvd_reg <= VDC_MV_I * VDC_MV_I;
         quo_reg <= 64'h0;
         rem_reg <= 33'h0;
         div_cnt_reg <= 7'h40;
      end else if (div_cnt_reg != 7'h00) begin
         dvd_reg <= {dvd_reg[62:0], 1'b0};
         rem_reg <= rem_ge ? rem_sh - {1'b0, res_reg} : rem_sh;
         quo_reg <= {quo_reg[62:0], rem_ge};
         div_cnt_reg <= div_cnt_reg - 7'h01;
         if (div_cnt_reg == 7'h01) begin
            pwr_reg <= (|quo_reg[62:31]) ? 32'hFFFFFFFF :
               {quo_reg[30:0], rem_ge};
         end
      end
   end

   // ****************************************************************
   // Energy accounting, one step per millisecond tick (units mW x ms)
   // ****************************************************************
   wire [47:0] add_e = (state_reg == ST_ON) ? {16'h0, pwr_reg} : 48'h0;
   wire [48:0] sum_e = {1'b0, acc_reg} + {1'b0, add_e};
   wire [48:0] cool_e = {17'h0, cool_reg};
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         acc_reg <= 48'h0;
         short_reg <= 48'h0;
         long_reg <= 48'h0;
         short_cnt_reg <= 32'h0;
         long_cnt_reg <= 32'h0;
      end else if (tick) begin
         // Saturates at zero so a cold resistor never goes negative.
         acc_reg <= (sum_e > cool_e) ? sum_e[47:0] - cool_e[47:0] :
            48'h0;
         // Fixed windows, not sliding ones: cheap, and a surge that
         // straddles a boundary is seen by the net accumulator instead.
         if (short_cnt_reg >= SHORT_WIN_MS - 1) begin
            short_cnt_reg <= 32'h0;
            short_reg <= add_e;
         end else begin
            short_cnt_reg <= short_cnt_reg + 32'h1;
            short_reg <= short_reg + add_e;
         end
         if (long_cnt_reg + 32'h1 >= lref_reg) begin
            long_cnt_reg <= 32'h0;
            long_reg <= add_e;
         end else begin
            long_cnt_reg <= long_cnt_reg + 32'h1;
            long_reg <= long_reg + add_e;
         end
      end
   end

   // ****************************************************************
   // Sticky status, error code and interrupt
   // ****************************************************************
   reg param_bad_d_reg;
   wire param_rise = param_bad && !param_bad_d_reg;
   wire [2:0] ev_set = {param_rise, block_rise, ov_event && !stage_off_reg};
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         status_reg <= 3'h0;
         code_reg <= `BCM_CODE_NONE;
         param_bad_d_reg <= 1'b0;
      end else begin
         param_bad_d_reg <= param_bad;
         // A read clears the flags, but an event in the same cycle wins.
         status_reg <= (rd_status ? 3'h0 : status_reg) | ev_set;
         if (param_rise)
            code_reg <= `BCM_CODE_PARAM;
         else if (block_rise)
            code_reg <= `BCM_CODE_OVERLOAD;
      end
   end

   assign IRQ_O = |(status_reg & mask_reg);
   assign BALLAST_O = pin_reg;
   assign STAGE_OFF_O = stage_off_reg;

endmodule

// >>> pkg/bcm_map.vh
// Register indices, field positions, reset values and timing counts of the
// ballast chopper monitor. Assumes it is included once per design file.
`ifndef BCM_MAP_VH
`define BCM_MAP_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define BCM_IDX_CFG 6'h01
`define BCM_IDX_THR 6'h02
`define BCM_IDX_HYST 6'h03
`define BCM_IDX_RES 6'h04
`define BCM_IDX_LLIM 6'h05
`define BCM_IDX_LREF 6'h06
`define BCM_IDX_SLIM 6'h07
`define BCM_IDX_COOL 6'h08
`define BCM_IDX_STATUS 6'h10
`define BCM_IDX_MASK 6'h11
`define BCM_IDX_STATE 6'h12
`define BCM_IDX_ENERGY 6'h13
`define BCM_IDX_OVLIM 6'h14
`define BCM_IDX_CODE 6'h15

// ****************************************************************
// Field positions
// ****************************************************************
`define BCM_CFG_EN 0
`define BCM_CFG_INV 1
`define BCM_ST_OVERVOLT 0
`define BCM_ST_OVERLOAD 1
`define BCM_ST_PARAM 2
`define BCM_STW 3

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define BCM_RST_WORD 32'h00000000
`define BCM_RST_OVLIM 32'hFFFFFFFF
`define BCM_CODE_NONE 16'h0000
`define BCM_CODE_OVERLOAD 16'h7113
`define BCM_CODE_PARAM 16'h7110
`define BCM_RESP_OKAY 2'h0
`define BCM_RESP_SLVERR 2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define BCM_CLK_NS 50
`define BCM_TICK_NS 1000000
`define BCM_TICK_CYC ((`BCM_TICK_NS + `BCM_CLK_NS - 1) / `BCM_CLK_NS)
`define BCM_SHORT_WIN_MS 999
`define BCM_MS_PER_S 1000

`endif

// >>> verif/bcm_props.sv
// Protocol and latch checks on the ballast chopper monitor top ports.
// Assumes a single clock domain and an asynchronous active low reset.
// ***************************************************************
// Checker
// ***************************************************************
module bcm_props (
   input wire CLK_SYS_I,
   input wire RSTN_I,
   input wire BALLAST_O,
   input wire STAGE_OFF_O,
   input wire IRQ_O,
   input wire S_AXI_AWVALID_I,
   input wire S_AXI_AWREADY_O,
   input wire S_AXI_WVALID_I,
   input wire S_AXI_WREADY_O,
   input wire [1:0] S_AXI_BRESP_O,
   input wire S_AXI_BVALID_O,
   input wire S_AXI_BREADY_I,
   input wire S_AXI_ARVALID_I,
   input wire S_AXI_ARREADY_O,
   input wire [31:0] S_AXI_RDATA_O,
   input wire S_AXI_RVALID_O,
   input wire S_AXI_RREADY_I
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);
   a_bvalid_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
      |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
      else $error("write response dropped early");
   a_rvalid_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
      |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
      else $error("read data dropped early");
   a_arready_follows: assert property (S_AXI_ARREADY_O == !S_AXI_RVALID_O)
      else $error("read address ready wrong");
   a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
      |=> S_AXI_RVALID_O) else $error("read answer late");
   a_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O &&
      S_AXI_WVALID_I && S_AXI_WREADY_O |-> ##[1:3] S_AXI_BVALID_O)
      else $error("write answer late");
   a_aw_blocked: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O
      |=> !S_AXI_AWREADY_O) else $error("second address accepted");
   a_bresp_code: assert property (S_AXI_BVALID_O
      |-> S_AXI_BRESP_O == 2'h0 || S_AXI_BRESP_O == 2'h2)
      else $error("write response code illegal");
   a_stage_latch: assert property (STAGE_OFF_O
      |=> STAGE_OFF_O || S_AXI_BVALID_O) else $error("stage off let go");
   c_pin_pulse: cover property (BALLAST_O ##1 !BALLAST_O);
   c_stage_off: cover property (!STAGE_OFF_O ##1 STAGE_OFF_O);
   c_irq: cover property (IRQ_O);
endmodule

bind bcm_top bcm_props u_props (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I),
   .BALLAST_O(BALLAST_O), .STAGE_OFF_O(STAGE_OFF_O), .IRQ_O(IRQ_O),
   .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
   .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
   .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
   .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
   .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
   .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I));

// >>> verif/bcm_switch_model.sv
// Driver, switch and resistor on the DC link, seen from the ballast pin.
// Assumes the bench tells it the configured pin polarity.
// ***************************************************************
// Far side model
// ***************************************************************
module bcm_switch_model (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic pin_i,
   input wire logic inv_i,
   input wire logic regen_i,
   input wire logic [31:0] set_mv_i,
   output logic sw_on_o,
   output logic [31:0] vdc_mv_o
);
   timeunit 1ns;
   timeprecision 1ns;
   assign sw_on_o = pin_i ^ inv_i;
   // Braking pumps the link up slowly; the resistor pulls it down fast.
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         vdc_mv_o <= 32'h00000000;
      end else if (!regen_i) begin
         vdc_mv_o <= set_mv_i;
      end else if (sw_on_o) begin
         vdc_mv_o <= vdc_mv_o - 32'h000000C8;
      end else begin
         vdc_mv_o <= vdc_mv_o + 32'h00000032;
      end
   end
endmodule

// >>> verif/bcm_tb_top.sv
// Self-checking bench of the ballast chopper monitor.
// Assumes the checker is bound in and the far side model is compiled.
module bcm_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rstn = 0, regen = 0, inv = 0, st = 0;
   logic [31:0] setmv = 0, wdata = 0, thr, hyst, d, v;
   logic [7:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [1:0] r;
   logic [31:0] cfgv [7];
   logic [31:0] vals [7];
   wire pin, stoff, irq, awrdy, wrdy, bvalid, arrdy, rvalid, sw_on;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata, vdc;
   int failures = 0, comparisons = 0, cyc = 0, n;
   always #25 clk = ~clk;
   bcm_top #(.TICK_CYCLES(100), .SHORT_WIN_MS(10)) DUT (.CLK_SYS_I(clk),
      .RSTN_I(rstn), .VDC_MV_I(vdc), .BALLAST_O(pin), .STAGE_OFF_O(stoff),
      .IRQ_O(irq), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
      .S_AXI_AWREADY_O(awrdy), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wrdy),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
      .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arrdy),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));
   bcm_switch_model PM (.clk_i(clk), .rstn_i(rstn), .pin_i(pin),
      .inv_i(inv), .regen_i(regen), .set_mv_i(setmv), .sw_on_o(sw_on),
      .vdc_mv_o(vdc));
   // ***************************************************************
   // Tasks and expectations
   // ***************************************************************
   task stop_test;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         failures++;
         stop_test();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // The response ready is raised one cycle after the handshake, on the same edge that raises the write response valid.
   task wr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
      logic aw, w;
      aw = 1;
      w = 1;
      awaddr <= a;
      wdata <= x;
      awvalid <= 1;
      wvalid <= 1;
      while (aw || w) begin
         @(posedge clk);
         if (aw && awrdy) begin
            aw = 0;
            awvalid <= 0;
         end
         if (w && wrdy) begin
            w = 0;
            wvalid <= 0;
         end
      end
      @(posedge clk);
      bready <= 1;
      do @(posedge clk); while (!bvalid);
      bready <= 0;
      chk(bresp, e);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1;
      do @(posedge clk); while (!arrdy);
      arvalid <= 0;
      @(posedge clk);
      rready <= 1;
      do @(posedge clk); while (!rvalid);
      rready <= 0;
      d = rdata;
      r = rresp;
      if (er !== 2'h3) chk(d, e);
      if (er !== 2'h3) chk(r, er);
   endtask
   task wpin(input logic e);
      n = 0;
      while (pin !== e && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk(pin, e);
   endtask
   function logic exp_on(input logic [31:0] x, input logic prev);
      if (x > thr) return 1;
      if (x < thr - hyst) return 0;
      return prev;
   endfunction
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   initial begin
      void'($urandom(95));
      repeat (3) @(posedge clk);
      rstn <= 1;
      @(posedge clk);
      for (int i = 1; i <= 8; i++) rd(8'(i * 4), 0, 2'h0);
      rd(8'h50, 32'hFFFFFFFF, 2'h0);
      rd(8'h3C, 0, 2'h2);
      wr(8'h3C, 1, 2'h2);
      wr(8'h48, 1, 2'h2);
      setmv <= 32'd60000;
      wr(8'h04, 1, 2'h0);
      repeat (4) @(posedge clk);
      chk(pin, 0);
      rd(8'h54, 32'h00007110, 2'h0);
      wr(8'h44, 4, 2'h0);
      chk(irq, 1);
      wr(8'h44, 0, 2'h0);
      chk(irq, 0);
      rd(8'h40, 4, 2'h0);
      thr = 20000 + $urandom % 20000;
      hyst = 100 + $urandom % 2000;
      cfgv = '{thr, hyst, 15000, 300, 10, 150, 20000};
      setmv <= 0;
      wr(8'h04, 0, 2'h0);
      for (int i = 0; i < 7; i++) wr(8'(8 + 4 * i), cfgv[i], 2'h0);
      wr(8'h04, 1, 2'h0);
      vals = '{thr, thr + 1, thr - hyst, thr - hyst - 1, thr + 2,
         thr - hyst + 1, thr - hyst - 2};
      for (int i = 0; i < 7; i++) begin
         setmv <= vals[i];
         // The link value lands one edge late and the pin one edge later.
         repeat (3) @(posedge clk);
         st = exp_on(vals[i], st);
         chk(pin, st);
      end
      setmv <= thr + 1 + $urandom % 1000;
      wpin(1);
      wpin(0);
      rd(8'h54, 32'h00007113, 2'h0);
      rd(8'h4C, 0, 2'h3);
      chk(d != 0, 1);
      rd(8'h40, 0, 2'h3);
      chk(d[1], 1);
      setmv <= thr - hyst - 1;
      n = 0;
      // A fixed surge window may need its full length before release.
      do begin
         rd(8'h48, 0, 2'h3);
         n++;
      end while (d[2] !== 0 && n < 400);
      chk(d[2], 0);
      repeat (1200) @(posedge clk);
      rd(8'h4C, 0, 2'h0);
      setmv <= thr + 1;
      wpin(1);
      wr(8'h50, thr + 3000, 2'h0);
      setmv <= thr + 4000;
      repeat (3) @(posedge clk);
      chk(stoff, 1);
      rd(8'h40, 0, 2'h3);
      chk(d[0], 1);
      setmv <= thr - hyst - 1;
      wr(8'h40, 1, 2'h0);
      chk(stoff, 0);
      inv <= 1;
      wr(8'h04, 3, 2'h0);
      repeat (2) @(posedge clk);
      chk(pin, 1);
      chk(sw_on, 0);
      setmv <= thr + 1;
      wr(8'h04, 2, 2'h0);
      repeat (2) @(posedge clk);
      chk(pin, 1);
      inv <= 0;
      wr(8'h04, 1, 2'h0);
      regen <= 1;
      repeat (200) @(posedge clk);
      chk(vdc < thr + 1000, 1);
      stop_test();
   end
endmodule
